/* File: verilog/segment_gate_protection.sv */
// Segmentation and call-gate protection unit with AHB-Lite register port
//
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module segment_gate_protection
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Descriptor memory read port
    output logic mem_req,
    output logic [63:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [63:0] mem_rdata,
    // Task state segment stack selector input, loaded when a gate call moves to a more privileged target level outside wide mode; wide mode loads the null selector
    input wire logic [15:0] tss_stack_sel,
    // Status
    output logic [1:0] op_mode,
    output logic [1:0] current_privilege_level,
    output logic gp_fault,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // Descriptor decode helpers

    function automatic logic [63:0] desc_base(input logic [127:0] d, input logic wide);
        logic [63:0] b;
        b = {32'h0000_0000, d[63:56], d[39:16]};
        if (wide)
            b[63:32] = d[95:64];
        return b;
    endfunction

    function automatic logic [63:0] entry_addr(input logic [63:0] tbase, input logic [12:0] idx,
                                               input logic wide);
        logic [63:0] step;
        step = wide ? 64'(seg_gate_pkg::WIDE_DESC_BYTES) : 64'(seg_gate_pkg::LEGACY_DESC_BYTES);
        return tbase + 64'(idx) * step;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus address phase capture

    seg_gate_pkg::ahb_addr_type aphase_q;
    logic bus_wr;
    logic bus_rd;
    logic [7:0] waddr;

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            aphase_q <= '0;
        else if (hready)
            aphase_q <= '{htrans: htrans, haddr: haddr, hwrite: hwrite, hsize: hsize, hsel: hsel};
    end

    assign bus_wr = aphase_q.hsel && aphase_q.htrans[1] && aphase_q.hwrite;
    assign bus_rd = hsel && htrans[1] && !hwrite && hready;
    assign waddr = aphase_q.haddr[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    seg_gate_pkg::op_mode_type mode_q;
    logic [63:0] gt_base_q;
    logic [15:0] lt_sel_q;
    logic [63:0] lt_base_q;
    logic [15:0] req_sel_q;
    logic [63:0] req_off_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [1:0] cpl_q;
    logic start_q;
    logic [1:0] cmd_q;
    logic wide_mode;
    logic busy;

    assign wide_mode = (mode_q == seg_gate_pkg::MODE_EXT64) || (mode_q == seg_gate_pkg::MODE_COMPAT);

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            mode_q <= seg_gate_pkg::MODE_REAL;
        else if (bus_wr && waddr == seg_gate_pkg::OFF_MODE_CTRL)
        begin
            case (hwdata[1:0])
                seg_gate_pkg::MODE_REQ_PROT:
                    mode_q <= seg_gate_pkg::MODE_PROT;
                seg_gate_pkg::MODE_REQ_EXT:
                    if (mode_q != seg_gate_pkg::MODE_REAL)
                        mode_q <= seg_gate_pkg::MODE_EXT64;
                seg_gate_pkg::MODE_REQ_COMPAT:
                    if (mode_q != seg_gate_pkg::MODE_REAL)
                        mode_q <= seg_gate_pkg::MODE_COMPAT;
                default:
                    mode_q <= mode_q;
            endcase
        end
    end

    // Upper base halves are stored in every mode and used for fetches in every mode but real; only readback masks them outside wide mode
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            gt_base_q <= '0;
            lt_sel_q <= '0;
            req_sel_q <= '0;
            req_off_q <= '0;
        end
        else if (bus_wr)
        begin
            case (waddr)
                seg_gate_pkg::OFF_GT_BASE_LO: gt_base_q[31:0] <= hwdata;
                seg_gate_pkg::OFF_GT_BASE_HI: gt_base_q[63:32] <= hwdata;
                seg_gate_pkg::OFF_LT_SEL: lt_sel_q <= hwdata[15:0];
                seg_gate_pkg::OFF_REQ_SEL: req_sel_q <= hwdata[15:0];
                seg_gate_pkg::OFF_REQ_OFFSET: req_off_q[31:0] <= hwdata;
                seg_gate_pkg::OFF_FETCH_ADDR_HI: req_off_q[63:32] <= hwdata;
                default: req_off_q <= req_off_q;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            start_q <= 1'b0;
            cmd_q <= '0;
        end
        else
        begin
            start_q <= bus_wr && waddr == seg_gate_pkg::OFF_REQ_CMD && !busy;
            if (bus_wr && waddr == seg_gate_pkg::OFF_REQ_CMD && !busy)
                cmd_q <= hwdata[1:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_mask_q <= seg_gate_pkg::IRQ_RESET;
        else if (bus_wr && waddr == seg_gate_pkg::OFF_IRQ_MASK)
            irq_mask_q <= hwdata[1:0];
    end

    ////////////////////////////////////////////////////////////////////////
    // Translation and gate state machine

    seg_gate_pkg::fsm_type st_q;
    logic [127:0] desc_q;
    logic [127:0] tgt_q;
    logic half_q;
    logic [63:0] lin_q;
    logic [15:0] res_sel_q;
    logic [15:0] stack_sel_q;
    logic fault_q;
    logic done_ev;
    logic gp_ev;
    seg_gate_pkg::selector_type sel;
    seg_gate_pkg::selector_type tsel;
    logic [63:0] tbl_base;
    logic [63:0] tgt_tbl_base;
    logic [1:0] dpl;
    logic [1:0] tgt_dpl;
    logic [4:0] dtype;
    logic wide_desc;

    assign busy = st_q != seg_gate_pkg::ST_IDLE;
    assign sel = req_sel_q;
    assign tsel = desc_q[31:16];
    assign wide_desc = mode_q == seg_gate_pkg::MODE_EXT64;
    assign tbl_base = sel.table_local ? lt_base_q : gt_base_q;
    assign tgt_tbl_base = tsel.table_local ? lt_base_q : gt_base_q;
    assign dpl = desc_q[seg_gate_pkg::DESC_DPL_LSB +: 2];
    assign tgt_dpl = tgt_q[seg_gate_pkg::DESC_DPL_LSB +: 2];
    assign dtype = {desc_q[44], desc_q[seg_gate_pkg::DESC_TYPE_LSB +: 4]};

    // Local table base is written directly over the bus; lt_sel_q does not load it
    always_ff @(posedge ref_clk)
    begin
        if (srst)
            lt_base_q <= '0;
        else if (bus_wr && waddr == seg_gate_pkg::OFF_LT_BASE_LO)
            lt_base_q[31:0] <= hwdata;
        else if (bus_wr && waddr == seg_gate_pkg::OFF_LT_BASE_HI)
            lt_base_q[63:32] <= hwdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            st_q <= seg_gate_pkg::ST_IDLE;
            desc_q <= '0;
            tgt_q <= '0;
            half_q <= 1'b0;
            lin_q <= '0;
            res_sel_q <= '0;
            stack_sel_q <= '0;
            fault_q <= 1'b0;
            done_ev <= 1'b0;
            gp_ev <= 1'b0;
            cpl_q <= seg_gate_pkg::CPL_RESET;
            mem_req <= 1'b0;
            mem_addr <= '0;
        end
        else
        begin
            done_ev <= 1'b0;
            gp_ev <= 1'b0;
            case (st_q)
                seg_gate_pkg::ST_IDLE:
                    if (start_q)
                    begin
                        fault_q <= 1'b0;
                        half_q <= 1'b0;
                        if (mode_q == seg_gate_pkg::MODE_REAL)
                        begin
                            lin_q <= {44'h0_0000_0000_0, req_sel_q, 4'h0} + req_off_q;
                            st_q <= seg_gate_pkg::ST_FINISH;
                        end
                        else
                        begin
                            mem_addr <= entry_addr(tbl_base, sel.index, wide_desc);
                            mem_req <= 1'b1;
                            st_q <= seg_gate_pkg::ST_FETCH_DESC;
                        end
                    end
                seg_gate_pkg::ST_FETCH_DESC:
                    if (mem_ack)
                    begin
                        if (!half_q)
                            desc_q[63:0] <= mem_rdata;
                        else
                            desc_q[127:64] <= mem_rdata;
                        // Second half only for 16-byte entries
                        if (wide_desc && !half_q)
                        begin
                            half_q <= 1'b1;
                            mem_addr <= mem_addr + 64'h0000_0000_0000_0008;
                        end
                        else
                        begin
                            mem_req <= 1'b0;
                            half_q <= 1'b0;
                            st_q <= seg_gate_pkg::ST_CHECK;
                        end
                    end
                seg_gate_pkg::ST_CHECK:
                    if (cmd_q == seg_gate_pkg::CMD_GATE_CALL)
                    begin
                        if ((wide_mode && dtype == seg_gate_pkg::TYPE_TASK_GATE)
                            || dtype != seg_gate_pkg::TYPE_CALL_GATE
                            || !desc_q[seg_gate_pkg::DESC_PRESENT_BIT]
                            || cpl_q > dpl || sel.rpl > dpl)
                        begin
                            fault_q <= 1'b1;
                            st_q <= seg_gate_pkg::ST_FINISH;
                        end
                        else
                        begin
                            mem_addr <= entry_addr(tgt_tbl_base, tsel.index, wide_desc);
                            mem_req <= 1'b1;
                            st_q <= seg_gate_pkg::ST_FETCH_TGT;
                        end
                    end
                    else
                    begin
                        if (!desc_q[seg_gate_pkg::DESC_PRESENT_BIT]
                            || (cpl_q > dpl) || (sel.rpl > dpl))
                            fault_q <= 1'b1;
                        else
                            lin_q <= desc_base(desc_q, wide_desc) + req_off_q;
                        res_sel_q <= req_sel_q;
                        st_q <= seg_gate_pkg::ST_FINISH;
                    end
                seg_gate_pkg::ST_FETCH_TGT:
                    if (mem_ack)
                    begin
                        if (!half_q)
                            tgt_q[63:0] <= mem_rdata;
                        else
                            tgt_q[127:64] <= mem_rdata;
                        if (wide_desc && !half_q)
                        begin
                            half_q <= 1'b1;
                            mem_addr <= mem_addr + 64'h0000_0000_0000_0008;
                        end
                        else
                        begin
                            mem_req <= 1'b0;
                            half_q <= 1'b0;
                            st_q <= seg_gate_pkg::ST_FETCH_STACK;
                        end
                    end
                seg_gate_pkg::ST_FETCH_STACK:
                begin
                    if (tgt_dpl > cpl_q || !tgt_q[seg_gate_pkg::DESC_PRESENT_BIT])
                        fault_q <= 1'b1;
                    else
                    begin
                        res_sel_q <= tsel;
                        // Entry offset from gate; 32-bit high half or 16-bit legacy, wide adds upper
                        lin_q <= {(wide_desc ? desc_q[95:64] : 32'h0000_0000),
                                  (desc_q[43] ? desc_q[63:48] : 16'h0000), desc_q[15:0]};
                        if (tgt_dpl < cpl_q)
                            stack_sel_q <= wide_mode ? seg_gate_pkg::NULL_SELECTOR
                                                     : tss_stack_sel;
                        cpl_q <= tgt_dpl;
                    end
                    st_q <= seg_gate_pkg::ST_FINISH;
                end
                seg_gate_pkg::ST_FINISH:
                begin
                    done_ev <= 1'b1;
                    gp_ev <= fault_q;
                    st_q <= seg_gate_pkg::ST_IDLE;
                end
                default:
                    st_q <= seg_gate_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status, set wins over write-one-to-clear

    always_ff @(posedge ref_clk)
    begin
        if (srst)
            irq_stat_q <= seg_gate_pkg::IRQ_RESET;
        else
        begin
            for (int i = 0; i < 2; i++)
                if ((i == seg_gate_pkg::IRQ_DONE_BIT && done_ev) || (i == seg_gate_pkg::IRQ_GP_BIT && gp_ev))
                    irq_stat_q[i] <= 1'b1;
                else if (bus_wr && waddr == seg_gate_pkg::OFF_IRQ_STAT && hwdata[i])
                    irq_stat_q[i] <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs and read data

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            irq <= 1'b0;
            gp_fault <= 1'b0;
            op_mode <= seg_gate_pkg::MODE_REAL;
            current_privilege_level <= seg_gate_pkg::CPL_RESET;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
        end
        else
        begin
            irq <= |(irq_stat_q & irq_mask_q);
            gp_fault <= gp_ev;
            op_mode <= mode_q;
            current_privilege_level <= cpl_q;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (bus_rd)
            begin
                case (haddr[7:0])
                    seg_gate_pkg::OFF_MODE_CTRL: hrdata <= {30'h0000_0000, mode_q};
                    seg_gate_pkg::OFF_MODE_STAT: hrdata <= {27'h000_0000, fault_q, busy, 1'b0, cpl_q};
                    seg_gate_pkg::OFF_GT_BASE_LO: hrdata <= gt_base_q[31:0];
                    seg_gate_pkg::OFF_GT_BASE_HI: hrdata <= wide_mode ? gt_base_q[63:32] : 32'h0000_0000;
                    seg_gate_pkg::OFF_LT_SEL: hrdata <= {16'h0000, lt_sel_q};
                    seg_gate_pkg::OFF_LT_BASE_LO: hrdata <= lt_base_q[31:0];
                    seg_gate_pkg::OFF_LT_BASE_HI: hrdata <= wide_mode ? lt_base_q[63:32] : 32'h0000_0000;
                    seg_gate_pkg::OFF_REQ_SEL: hrdata <= {16'h0000, req_sel_q};
                    seg_gate_pkg::OFF_REQ_OFFSET: hrdata <= req_off_q[31:0];
                    seg_gate_pkg::OFF_RES_LIN_LO: hrdata <= lin_q[31:0];
                    seg_gate_pkg::OFF_RES_LIN_HI: hrdata <= lin_q[63:32];
                    seg_gate_pkg::OFF_RES_SEL: hrdata <= {16'h0000, res_sel_q};
                    seg_gate_pkg::OFF_DESC0: hrdata <= desc_q[31:0];
                    seg_gate_pkg::OFF_DESC1: hrdata <= desc_q[63:32];
                    seg_gate_pkg::OFF_DESC2: hrdata <= desc_q[95:64];
                    seg_gate_pkg::OFF_DESC3: hrdata <= desc_q[127:96];
                    seg_gate_pkg::OFF_TGT0: hrdata <= tgt_q[31:0];
                    seg_gate_pkg::OFF_TGT1: hrdata <= tgt_q[63:32];
                    seg_gate_pkg::OFF_STACK_SEL: hrdata <= {16'h0000, stack_sel_q};
                    seg_gate_pkg::OFF_IRQ_STAT: hrdata <= {30'h0000_0000, irq_stat_q};
                    seg_gate_pkg::OFF_IRQ_MASK: hrdata <= {30'h0000_0000, irq_mask_q};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: verilog/seg_gate_pkg.sv */
// Package for the segmentation and call-gate protection unit
package seg_gate_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_MODE_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE_STAT = 8'h04;
    localparam logic [7:0] OFF_GT_BASE_LO = 8'h08;
    localparam logic [7:0] OFF_GT_BASE_HI = 8'h0C;
    localparam logic [7:0] OFF_LT_SEL = 8'h10;
    localparam logic [7:0] OFF_LT_BASE_LO = 8'h14;
    localparam logic [7:0] OFF_LT_BASE_HI = 8'h18;
    localparam logic [7:0] OFF_REQ_SEL = 8'h1C;
    localparam logic [7:0] OFF_REQ_OFFSET = 8'h20;
    localparam logic [7:0] OFF_REQ_CMD = 8'h24;
    localparam logic [7:0] OFF_RES_LIN_LO = 8'h28;
    localparam logic [7:0] OFF_RES_LIN_HI = 8'h2C;
    localparam logic [7:0] OFF_RES_SEL = 8'h30;
    localparam logic [7:0] OFF_DESC0 = 8'h34;
    localparam logic [7:0] OFF_DESC1 = 8'h38;
    localparam logic [7:0] OFF_DESC2 = 8'h3C;
    localparam logic [7:0] OFF_DESC3 = 8'h40;
    localparam logic [7:0] OFF_TGT0 = 8'h44;
    localparam logic [7:0] OFF_TGT1 = 8'h48;
    localparam logic [7:0] OFF_STACK_SEL = 8'h4C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h50;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h54;
    localparam logic [7:0] OFF_FETCH_ADDR_LO = 8'h58;
    localparam logic [7:0] OFF_FETCH_ADDR_HI = 8'h5C;

    // Mode control write codes
    localparam logic [1:0] MODE_REQ_PROT = 2'h1;
    localparam logic [1:0] MODE_REQ_EXT = 2'h2;
    localparam logic [1:0] MODE_REQ_COMPAT = 2'h3;

    // Command codes
    localparam logic [1:0] CMD_ACCESS = 2'h1;
    localparam logic [1:0] CMD_GATE_CALL = 2'h2;

    // Descriptor field positions (legacy 8-byte layout)
    localparam int unsigned DESC_TYPE_LSB = 40;
    localparam int unsigned DESC_DPL_LSB = 45;
    localparam int unsigned DESC_PRESENT_BIT = 47;
    localparam int unsigned DESC_DB_BIT = 54;
    localparam int unsigned DESC_L_BIT = 53;

    // Descriptor type codes
    localparam logic [4:0] TYPE_CALL_GATE = 5'h0C;
    localparam logic [4:0] TYPE_TASK_GATE = 5'h05;

    // Entry sizes in bytes and the null selector
    localparam logic [4:0] LEGACY_DESC_BYTES = 5'h08;
    localparam logic [4:0] WIDE_DESC_BYTES = 5'h10;
    localparam logic [15:0] NULL_SELECTOR = 16'h0000;

    // Status and interrupt bits
    localparam int unsigned IRQ_DONE_BIT = 0;
    localparam int unsigned IRQ_GP_BIT = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [1:0] CPL_RESET = 2'h0;

    typedef enum logic [1:0]
    {
        MODE_REAL = 2'b00,
        MODE_PROT = 2'b01,
        MODE_EXT64 = 2'b10,
        MODE_COMPAT = 2'b11
    } op_mode_type;

    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_FETCH_DESC = 3'b001,
        ST_CHECK = 3'b010,
        ST_FETCH_TGT = 3'b011,
        ST_FETCH_STACK = 3'b100,
        ST_FINISH = 3'b101
    } fsm_type;

    typedef struct packed
    {
        logic [12:0] index;
        logic table_local;
        logic [1:0] rpl;
    } selector_type;

    typedef struct packed
    {
        logic [1:0] htrans;
        logic [31:0] haddr;
        logic hwrite;
        logic [2:0] hsize;
        logic hsel;
    } ahb_addr_type;

endpackage

/* File: verilog/unused_placeholder_removed.sv */
// Intentionally minimal: no additional logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: verification/seg_gate_props.sv */
// Assertion checker for the segment gate protection unit
`timescale 1ns/1ps
`default_nettype none
module seg_gate_props
(
    // Clock, reset and watched ports
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [1:0] op_mode,
    input wire logic gp_fault
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence fault_pulse;
        gp_fault ##1 !gp_fault;
    endsequence
    sequence fetch_wait;
        mem_req && !mem_ack;
    endsequence
    reset_real_a: assert property ($fell(srst) |-> op_mode == 2'h0)
        else $error("mode not real after reset");
    real_exit_a: assert property ($past(op_mode) == 2'h0 && op_mode != 2'h0 |-> op_mode == 2'h1)
        else $error("real mode left for other than protected");
    ext_entry_a: assert property (op_mode[1] && !$past(op_mode[1]) |-> $past(op_mode) == 2'h1)
        else $error("wide mode entered from other than protected");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus wait or error response");
    fetch_hold_a: assert property (fetch_wait |=> mem_req && $stable(mem_addr))
        else $error("fetch dropped or moved before ack");
    real_nofetch_a: assert property (op_mode == 2'h0 |-> !mem_req)
        else $error("table fetch in real mode");
    fault_pulse_a: assert property ($rose(gp_fault) |-> fault_pulse)
        else $error("fault not a one cycle pulse");
    legacy_beat_a: assert property (mem_ack && op_mode != 2'h2 |=> !mem_req)
        else $error("second beat on a legacy descriptor");
endmodule
`default_nettype wire

/* File: verification/desc_mem_model.sv */
// Descriptor table memory answering the fetch port
`timescale 1ns/1ps
`default_nettype none
module desc_mem_model
(
    // Clock and fetch port
    input wire logic ref_clk,
    input wire logic mem_req,
    input wire logic [63:0] mem_addr,
    output logic mem_ack,
    output logic [63:0] mem_rdata
);
    logic [63:0] mem [0:63];
    int lat = 0;
    int cnt = 0;
    initial
    begin
        mem_ack = 1'b0;
        mem_rdata = 64'h0000_0000_0000_0000;
    end
    // Idle data toggles so a stale beat never looks valid
    always @(posedge ref_clk)
    begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && !mem_ack)
        begin
            cnt <= (cnt >= lat) ? 0 : cnt + 1;
            if (cnt >= lat)
            begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr[8:3]];
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb_segment_gate_protection.sv */
// Testbench for the segment gate protection unit
`timescale 1ns/1ps
`default_nettype none
module tb_segment_gate_protection;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, mem_req, mem_ack, gp_fault, irq;
    logic [63:0] mem_addr, mem_rdata;
    logic [1:0] op_mode, current_privilege_level;
    int err_total = 0;
    int tests_run = 0;
    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end
    segment_gate_protection segment_gate_protection_inst(.ref_clk, .srst, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .mem_req, .mem_addr, .mem_ack,
        .mem_rdata, .tss_stack_sel(16'h002B), .op_mode, .current_privilege_level, .gp_fault, .irq);
    desc_mem_model desc_mem_model_inst(.ref_clk, .mem_req, .mem_addr, .mem_ack, .mem_rdata);
    ////////////////////////////////////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task rdy;
        int n;
        n = 0;
        do begin @(posedge ref_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1)
        begin
            err_total++;
            summarize();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        haddr <= {24'h00_0000, a};
        htrans <= 2'h2;
        hwrite <= w;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        rd = hrdata;
    endtask
    task rdc(input string s, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        chk(s, e, rd);
    endtask
    // Start a request, poll the done bit, then check both status bits
    task run(input logic [15:0] sel, input logic [31:0] off, input logic [1:0] cmd, input logic [31:0] st);
        int n;
        bus(1'b1, seg_gate_pkg::OFF_REQ_SEL, {16'h0000, sel});
        bus(1'b1, seg_gate_pkg::OFF_REQ_OFFSET, off);
        bus(1'b1, seg_gate_pkg::OFF_REQ_CMD, {30'h0, cmd});
        n = 0;
        do begin bus(1'b0, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0000); n++; end while (rd[0] !== 1'b1 && n < 50);
        chk("status", st, rd);
        if (rd[0] !== 1'b1)
            summarize();
    endtask
    function automatic logic [63:0] seg(input logic [31:0] b, input logic [4:0] t, input logic [1:0] dpl);
        return {b[31:24], 8'h4F, 1'b1, dpl, t, b[23:0], 16'hFFFF};
    endfunction
    function automatic logic [63:0] gate(input logic [15:0] off, input logic [15:0] sel, input logic [4:0] t,
        input logic [1:0] dpl);
        return {16'h0000, 1'b1, dpl, t, 8'h00, sel, off};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        desc_mem_model_inst.mem[33] = seg(32'h0034_5000, 5'h12, 2'h0);
        desc_mem_model_inst.mem[34] = gate(16'h0400, 16'h0018, seg_gate_pkg::TYPE_CALL_GATE, 2'h3);
        desc_mem_model_inst.mem[35] = seg(32'h0000_9000, 5'h1A, 2'h0);
        desc_mem_model_inst.mem[36] = gate(16'h0400, 16'h0028, seg_gate_pkg::TYPE_CALL_GATE, 2'h3);
        desc_mem_model_inst.mem[37] = seg(32'h0000_9000, 5'h1A, 2'h3);
        desc_mem_model_inst.mem[38] = gate(16'h0000, 16'h0018, seg_gate_pkg::TYPE_TASK_GATE, 2'h3);
        desc_mem_model_inst.mem[39] = 64'h0000_0000_0000_0000;
        desc_mem_model_inst.mem[48] = seg(32'h0000_2000, 5'h12, 2'h3);
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        chk("op_mode", 32'h0, {30'h0, op_mode});
        chk("cpl", 32'h0, {30'h0, current_privilege_level});
        run(16'h0012, 32'h0000_0003, seg_gate_pkg::CMD_ACCESS, 32'h1);
        rdc("real_lin", seg_gate_pkg::OFF_RES_LIN_LO, 32'h0000_0123);
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        bus(1'b1, seg_gate_pkg::OFF_MODE_CTRL, 32'h0000_0002);
        rdc("mode_stat", seg_gate_pkg::OFF_MODE_STAT, 32'h0000_0000);
        chk("op_mode", 32'h0, {30'h0, op_mode});
        bus(1'b1, seg_gate_pkg::OFF_MODE_CTRL, 32'h0000_0001);
        bus(1'b1, seg_gate_pkg::OFF_GT_BASE_HI, 32'h0000_0005);
        rdc("gt_hi", seg_gate_pkg::OFF_GT_BASE_HI, 32'h0000_0000);
        chk("op_mode", 32'h1, {30'h0, op_mode});
        $display("test modes done");
        bus(1'b1, seg_gate_pkg::OFF_IRQ_MASK, 32'h0000_0001);
        bus(1'b1, seg_gate_pkg::OFF_GT_BASE_LO, 32'h0000_0100);
        run(16'h0008, 32'h0000_0010, seg_gate_pkg::CMD_ACCESS, 32'h1);
        rdc("lin", seg_gate_pkg::OFF_RES_LIN_LO, 32'h0034_5010);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        bus(1'b1, seg_gate_pkg::OFF_LT_BASE_LO, 32'h0000_0180);
        chk("irq", 32'h0, {31'h0, irq});
        run(16'h0004, 32'h0000_0020, seg_gate_pkg::CMD_ACCESS, 32'h1);
        rdc("lin", seg_gate_pkg::OFF_RES_LIN_LO, 32'h0000_2020);
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        $display("test access done");
        bus(1'b1, seg_gate_pkg::OFF_IRQ_MASK, 32'h0000_0002);
        run(16'h000B, 32'h0000_0000, seg_gate_pkg::CMD_ACCESS, 32'h3);
        chk("irq", 32'h1, {31'h0, irq});
        bus(1'b1, seg_gate_pkg::OFF_IRQ_MASK, 32'h0000_0000);
        rdc("stat", seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        chk("irq", 32'h0, {31'h0, irq});
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        $display("test fault done");
        desc_mem_model_inst.lat = 3;
        run(16'h0010, 32'h0000_0077, seg_gate_pkg::CMD_GATE_CALL, 32'h1);
        rdc("tsel", seg_gate_pkg::OFF_RES_SEL, 32'h0000_0018);
        rdc("entry", seg_gate_pkg::OFF_RES_LIN_LO, 32'h0000_0400);
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0001);
        run(16'h0020, 32'h0000_0000, seg_gate_pkg::CMD_GATE_CALL, 32'h3);
        bus(1'b1, seg_gate_pkg::OFF_IRQ_STAT, 32'h0000_0003);
        $display("test gate done");
        bus(1'b1, seg_gate_pkg::OFF_MODE_CTRL, 32'h0000_0002);
        bus(1'b1, seg_gate_pkg::OFF_GT_BASE_HI, 32'h0000_0005);
        rdc("gt_hi", seg_gate_pkg::OFF_GT_BASE_HI, 32'h0000_0005);
        chk("op_mode", 32'h2, {30'h0, op_mode});
        run(16'h0018, 32'h0000_0000, seg_gate_pkg::CMD_GATE_CALL, 32'h3);
        rdc("unmapped", 8'h60, 32'h0000_0000);
        $display("test wide done");
        summarize();
    end
endmodule
bind segment_gate_protection seg_gate_props seg_gate_props_inst(.ref_clk, .srst, .hreadyout, .hresp, .mem_req,
    .mem_addr, .mem_ack, .op_mode, .gp_fault);
`default_nettype wire
